// ===== design/btc_ctrl.sv
// batch counting timer front panel, set value edit, control and batch outputs
// What this block does
// - each digit key press raises its column by one, any order
// - while editing, control output turns on once set value drops to or below present
// - leading zeros of the batch set value are blanked
// - batch key shows batch count in run mode, display key returns to present value
// - timing keeps running when run mode switches to setting mode
// - mode key ignored while key protection is on
// - setting mode changes held pending until run mode returns
// - one-shot output time programmable from 0.1 s to 99.9 s
// - batch count held at zero while batch reset is on
// - batch set value zero: counting goes on, batch output set only by power-up restore
// - batch count wraps from 9999 to zero
// - timer reset key or input leaves batch count and output alone
// - batch output state restored after power returns
// - lowering batch set value below count turns batch output on
// - batch output stays on after set value raised; only batch reset or a fault clears
// - fault shows error code, clears present value, forces outputs off
// - batch output set when batch count equals batch set value
// - batch reset rising edge clears count and output, counts ignored meanwhile
//
// Our own choices: the address map and the AXI4-Lite slave port.
module btc_ctrl #(
   parameter int unsigned TICK_CYC = btc_pkg::TICK_CYC
) (
   // clock and reset
   input  wire  logic              core_clk,
   input  wire  logic              rst,
   // operator pins
   input  wire  btc_pkg::btc_keys_s keys,
   input  wire  logic              tmr_reset_in,
   input  wire  logic              batch_reset_in,
   input  wire  logic              key_protect_in,
   input  wire  logic              cpu_fault_in,
   input  wire  logic              mem_fault_in,
   input  wire  logic              batch_saved_in,
   // timing core
   input  wire  logic [15:0]       timer_pv,
   input  wire  logic              timing_done,
   output logic                    pv_clear,
   output logic                    timing_run,
   // outputs and display
   output logic                    ctrl_out,
   output logic                    batch_out,
   output logic [3:0]              batch_blank,
   output logic [1:0]              err_code,
   output logic                    view_batch,
   output logic                    setting_mode,
   // axi4-lite slave
   input  wire  logic [7:0]        s_axi_awaddr,
   input  wire  logic              s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire  logic [31:0]       s_axi_wdata,
   input  wire  logic [3:0]        s_axi_wstrb,
   input  wire  logic              s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire  logic              s_axi_bready,
   input  wire  logic [7:0]        s_axi_araddr,
   input  wire  logic              s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire  logic              s_axi_rready
);
   function automatic logic [3:0] dig_inc(input logic [3:0] d);
      return (d >= 4'h9) ? 4'h0 : d + 4'h1;
   endfunction

   function automatic logic [15:0] bcd4_inc(input logic [15:0] v);
      logic [15:0] r;
      logic        c;
      r = v;
      c = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (c) begin
            r[i*4 +: 4] = dig_inc(v[i*4 +: 4]);
            c = (v[i*4 +: 4] >= 4'h9);
         end
      end
      return r;
   endfunction

   function automatic logic [9:0] bcd3_bin(input logic [11:0] b);
      return 10'(b[11:8]) * 10'h064 + 10'(b[7:4]) * 10'h00A + 10'(b[3:0]);
   endfunction

   // synchronise every pin, then find rising edges
   logic [13:0] sync1_r, sync2_r, prev_r, rise;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sync1_r <= 14'h0000;
         sync2_r <= 14'h0000;
         prev_r  <= 14'h0000;
      end else begin
         sync1_r <= {keys, tmr_reset_in, batch_reset_in, key_protect_in,
                     cpu_fault_in, mem_fault_in, batch_saved_in};
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end
   assign rise = sync2_r & ~prev_r;

   btc_pkg::btc_keys_s key_p;
   logic tmr_rst_s, brst_s, brst_rise, protect_s, cpu_s, mem_s, saved_s;
   assign key_p     = rise[13:6];
   assign tmr_rst_s = sync2_r[5];
   assign brst_s    = sync2_r[4];
   assign brst_rise = rise[4];
   assign protect_s = sync2_r[3];
   assign cpu_s     = sync2_r[2];
   assign mem_s     = sync2_r[1];
   assign saved_s   = sync2_r[0];

   // bus write decode
   logic        aw_have_r, w_have_r, bvalid_r, rvalid_r;
   logic [7:0]  awaddr_r;
   logic [31:0] wdata_r, rdata_r;
   logic [3:0]  wstrb_r;
   logic [1:0]  bresp_r, rresp_r;
   logic        wr_go, wr_sv, wr_bsv;
   assign wr_go  = aw_have_r && w_have_r && !bvalid_r;
   assign wr_sv  = wr_go && awaddr_r == btc_pkg::OFS_TIMER_SV;
   assign wr_bsv = wr_go && awaddr_r == btc_pkg::OFS_BATCH_SV;

   // mode, view and error state
   btc_pkg::btc_mode_e mode_r;
   btc_pkg::btc_view_e view_r;
   logic [1:0] err_r;
   logic       rst_key_p;
   assign rst_key_p = key_p.reset;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mode_r <= btc_pkg::MODE_RUN;
      end else begin
         unique case (mode_r)
            btc_pkg::MODE_RUN: begin
               if (key_p.mode && !protect_s) begin
                  mode_r <= btc_pkg::MODE_SET;
               end
            end
            btc_pkg::MODE_SET: begin
               if (key_p.disp) begin
                  mode_r <= btc_pkg::MODE_RUN;
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         view_r <= btc_pkg::VIEW_PV;
      end else if (key_p.disp) begin
         view_r <= btc_pkg::VIEW_PV;
      end else if (key_p.batch && mode_r == btc_pkg::MODE_RUN) begin
         view_r <= btc_pkg::VIEW_BATCH;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         err_r <= btc_pkg::ERR_NONE;
      end else if (cpu_s) begin
         err_r <= btc_pkg::ERR_CPU;
      end else if (mem_s) begin
         err_r <= btc_pkg::ERR_MEM;
      end else if (rst_key_p) begin
         err_r <= btc_pkg::ERR_NONE;
      end
   end

   // set values: live run-mode edits, pending setting-mode edits
   logic [15:0] sv_r, bsv_r;
   logic [11:0] osh_pend_r, osh_act_r, osh_edit;
   logic        hold_pend_r, hold_act_r;
   always_comb begin
      osh_edit = osh_pend_r;
      for (int i = 0; i < 3; i++) begin
         if (key_p.inc[i]) begin
            osh_edit[i*4 +: 4] = dig_inc(osh_pend_r[i*4 +: 4]);
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sv_r  <= btc_pkg::SV_RST;
         bsv_r <= btc_pkg::BSV_RST;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (key_p.inc[i] && mode_r == btc_pkg::MODE_RUN) begin
               if (view_r == btc_pkg::VIEW_PV) begin
                  sv_r[i*4 +: 4] <= dig_inc(sv_r[i*4 +: 4]);
               end else begin
                  bsv_r[i*4 +: 4] <= dig_inc(bsv_r[i*4 +: 4]);
               end
            end
         end
         if (wr_sv) begin
            if (wstrb_r[0]) sv_r[7:0] <= wdata_r[7:0];
            if (wstrb_r[1]) sv_r[15:8] <= wdata_r[15:8];
         end
         if (wr_bsv) begin
            if (wstrb_r[0]) bsv_r[7:0] <= wdata_r[7:0];
            if (wstrb_r[1]) bsv_r[15:8] <= wdata_r[15:8];
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         osh_pend_r  <= btc_pkg::OSH_RST;
         osh_act_r   <= btc_pkg::OSH_RST;
         hold_pend_r <= 1'b1;
         hold_act_r  <= 1'b1;
      end else if (mode_r == btc_pkg::MODE_SET) begin
         // one-shot time never below 0.1 s
         osh_pend_r <= (osh_edit == 12'h000) ? btc_pkg::OSH_MIN : osh_edit;
         if (key_p.inc[3]) begin
            hold_pend_r <= !hold_pend_r;
         end
         if (key_p.disp) begin
            osh_act_r  <= osh_pend_r;
            hold_act_r <= hold_pend_r;
         end
      end
   end

   logic [3:0] blank_r;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         blank_r <= 4'hE;
      end else begin
         blank_r[3] <= bsv_r[15:12] == 4'h0;
         blank_r[2] <= bsv_r[15:8] == 8'h00;
         blank_r[1] <= bsv_r[15:4] == 12'h000;
         blank_r[0] <= 1'b0;
      end
   end

   // control output with one-shot timer
   logic        ctrl_hit, ctrl_latch_r, ctrl_out_r, pv_clear_r, run_r;
   logic [9:0]  osh_left_r;
   logic [31:0] tick_r;
   assign ctrl_hit = timer_pv >= sv_r;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tick_r <= 32'h0000_0000;
      end else begin
         tick_r <= (tick_r >= TICK_CYC - 1) ? 32'h0000_0000 : tick_r + 32'h0000_0001;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrl_latch_r <= 1'b0;
         osh_left_r   <= 10'h000;
      end else if (err_r != btc_pkg::ERR_NONE || tmr_rst_s || rst_key_p) begin
         ctrl_latch_r <= 1'b0;
         osh_left_r   <= 10'h000;
      end else if (ctrl_hit && !ctrl_latch_r) begin
         ctrl_latch_r <= 1'b1;
         osh_left_r   <= bcd3_bin(osh_act_r);
      end else if (tick_r == 32'h0000_0000 && osh_left_r != 10'h000) begin
         osh_left_r <= osh_left_r - 10'h001;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrl_out_r <= 1'b0;
         pv_clear_r <= 1'b0;
         run_r      <= 1'b0;
      end else begin
         ctrl_out_r <= ctrl_latch_r && (hold_act_r || osh_left_r != 10'h000)
                       && err_r == btc_pkg::ERR_NONE;
         pv_clear_r <= tmr_rst_s || rst_key_p || err_r != btc_pkg::ERR_NONE;
         run_r      <= err_r == btc_pkg::ERR_NONE;
      end
   end

   // batch counter, timer reset never reaches it
   logic [15:0] bcount_r;
   logic        bout_r, count_ev, restore_load, bhit;
   logic [1:0]  restore_cnt_r;
   assign restore_load = restore_cnt_r == btc_pkg::RESTORE_CYC - 2'h1;
   assign count_ev     = timing_done && !brst_s;
   assign bhit         = bsv_r != 16'h0000 && bcount_r >= bsv_r;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         restore_cnt_r <= 2'h0;
      end else if (restore_cnt_r != btc_pkg::RESTORE_CYC) begin
         restore_cnt_r <= restore_cnt_r + 2'h1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bcount_r <= 16'h0000;
      // held at zero under batch reset
      end else if (brst_s || err_r != btc_pkg::ERR_NONE) begin
         bcount_r <= 16'h0000;
      // one count per completed timing, wraps
      end else if (count_ev) begin
         bcount_r <= bcd4_inc(bcount_r);
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bout_r <= 1'b0;
      end else if (err_r != btc_pkg::ERR_NONE || brst_rise) begin
         bout_r <= 1'b0;
      // reload saved state after power up
      end else if (restore_load) begin
         bout_r <= saved_s;
      end else if (bhit) begin
         bout_r <= 1'b1;
      end
   end

   // axi4-lite slave
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         awaddr_r  <= 8'h00;
         wdata_r   <= 32'h0000_0000;
         wstrb_r   <= 4'h0;
         bresp_r   <= btc_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= (wr_sv || wr_bsv) ? btc_pkg::RESP_OKAY : btc_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   btc_pkg::btc_status_s st;
   assign st = '{err: err_r, view: view_r, mode: mode_r, batch_out: bout_r,
                 ctrl_out: ctrl_out_r};

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= btc_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_r <= 1'b1;
         rresp_r  <= btc_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            btc_pkg::OFS_STATUS:   rdata_r <= {26'h0000000, st};
            btc_pkg::OFS_BATCH_PV: rdata_r <= {16'h0000, bcount_r};
            btc_pkg::OFS_TIMER_SV: rdata_r <= {16'h0000, sv_r};
            btc_pkg::OFS_BATCH_SV: rdata_r <= {16'h0000, bsv_r};
            btc_pkg::OFS_OSH_TIME: rdata_r <= {19'h00000, hold_act_r, osh_act_r};
            default: begin
               rdata_r <= 32'h0000_0000;
               rresp_r <= btc_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   assign s_axi_awready = !aw_have_r && !bvalid_r;
   assign s_axi_wready  = !w_have_r && !bvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

   assign ctrl_out     = ctrl_out_r;
   assign batch_out    = bout_r;
   assign batch_blank  = blank_r;
   assign err_code     = err_r;
   assign view_batch   = view_r == btc_pkg::VIEW_BATCH;
   assign setting_mode = mode_r == btc_pkg::MODE_SET;
   assign pv_clear     = pv_clear_r;
   assign timing_run   = run_r;

   // checks
   sequence s_forced;
      err_r != btc_pkg::ERR_NONE ##1 !ctrl_out_r && !bout_r && bcount_r == 16'h0000;
   endsequence
   property p_key_inc;
      @(posedge core_clk) disable iff (rst)
      key_p.inc[0] && mode_r == btc_pkg::MODE_RUN && view_r == btc_pkg::VIEW_PV && !wr_sv
      |=> sv_r[3:0] == dig_inc($past(sv_r[3:0]));
   endproperty
   a_key_inc: assert property (p_key_inc) else $error("digit key did not step");
   property p_ctrl_on;
      @(posedge core_clk) disable iff (rst)
      ctrl_hit && err_r == btc_pkg::ERR_NONE && !tmr_rst_s && !rst_key_p |=> ctrl_latch_r;
   endproperty
   a_ctrl_on: assert property (p_ctrl_on) else $error("control not latched");
   property p_blank;
      @(posedge core_clk) disable iff (rst)
      bsv_r[15:12] != 4'h0 |=> blank_r == 4'h0;
   endproperty
   a_blank: assert property (p_blank) else $error("significant digit blanked");
   property p_protect;
      @(posedge core_clk) disable iff (rst)
      key_p.mode && protect_s && mode_r == btc_pkg::MODE_RUN |=> mode_r == btc_pkg::MODE_RUN;
   endproperty
   a_protect: assert property (p_protect) else $error("mode key not locked");
   property p_pending;
      @(posedge core_clk) disable iff (rst)
      mode_r == btc_pkg::MODE_SET && !key_p.disp |=> $stable(osh_act_r);
   endproperty
   a_pending: assert property (p_pending) else $error("pending value applied early");
   property p_brst_rise;
      @(posedge core_clk) disable iff (rst)
      brst_rise |=> bcount_r == 16'h0000 && !bout_r;
   endproperty
   a_brst_rise: assert property (p_brst_rise) else $error("batch reset failed");
   property p_wrap;
      @(posedge core_clk) disable iff (rst)
      count_ev && bcount_r == btc_pkg::BCD_MAX && err_r == btc_pkg::ERR_NONE
      |=> bcount_r == 16'h0000;
   endproperty
   a_wrap: assert property (p_wrap) else $error("batch count did not wrap");
   property p_no_out_zero;
      @(posedge core_clk) disable iff (rst)
      $rose(bout_r) |-> $past(bsv_r) != 16'h0000 || $past(restore_load);
   endproperty
   a_no_out_zero: assert property (p_no_out_zero) else $error("output at zero preset");
   property p_hold_on;
      @(posedge core_clk) disable iff (rst)
      bout_r && !brst_rise && err_r == btc_pkg::ERR_NONE |=> bout_r;
   endproperty
   a_hold_on: assert property (p_hold_on) else $error("batch output dropped");
   property p_tmr_rst;
      @(posedge core_clk) disable iff (rst)
      tmr_rst_s && !brst_s && !count_ev && err_r == btc_pkg::ERR_NONE |=> $stable(bcount_r);
   endproperty
   a_tmr_rst: assert property (p_tmr_rst) else $error("timer reset hit batch");
   property p_fault;
      @(posedge core_clk) disable iff (rst)
      cpu_s |=> s_forced;
   endproperty
   a_fault: assert property (p_fault) else $error("fault did not force outputs");
endmodule // btc_ctrl

// ===== design/btc_pkg.sv
// constants, types and register map of the batch counting timer control block
package btc_pkg;
   // clock and one-shot tick timing
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned TENTH_S_NS    = 100_000_000;
   localparam int unsigned TICK_CYC      = TENTH_S_NS / CLK_PERIOD_NS;

   // register byte offsets
   localparam logic [7:0] OFS_STATUS   = 8'h00;
   localparam logic [7:0] OFS_BATCH_PV = 8'h04;
   localparam logic [7:0] OFS_TIMER_SV = 8'h08;
   localparam logic [7:0] OFS_BATCH_SV = 8'h0C;
   localparam logic [7:0] OFS_OSH_TIME = 8'h10;

   // values after reset, limits and power-up restore delay
   localparam logic [15:0] SV_RST      = 16'h0000;
   localparam logic [15:0] BSV_RST     = 16'h0000;
   localparam logic [11:0] OSH_RST     = 12'h001;
   localparam logic [11:0] OSH_MIN     = 12'h001;
   localparam logic [15:0] BCD_MAX     = 16'h9999;
   localparam logic [1:0]  RESTORE_CYC = 2'h3;

   // error codes shown on the display
   localparam logic [1:0] ERR_NONE = 2'h0;
   localparam logic [1:0] ERR_CPU  = 2'h1;
   localparam logic [1:0] ERR_MEM  = 2'h2;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [0:0] {
      MODE_RUN = 1'b0,
      MODE_SET = 1'b1
   } btc_mode_e;

   typedef enum logic [0:0] {
      VIEW_PV    = 1'b0,
      VIEW_BATCH = 1'b1
   } btc_view_e;

   // front panel keys, one bit per key
   typedef struct packed {
      logic [3:0] inc;
      logic       mode;
      logic       disp;
      logic       batch;
      logic       reset;
   } btc_keys_s;

   // status word layout
   typedef struct packed {
      logic [1:0] err;
      logic       view;
      logic       mode;
      logic       batch_out;
      logic       ctrl_out;
   } btc_status_s;
endpackage : btc_pkg

// ===== testbench/testbench.sv
// self-checking bench of the batch counting timer control block
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic               core_clk = 1'b0;
   logic               rst = 1'b1;
   btc_pkg::btc_keys_s keys = '0;
   logic               tmr_reset_in = 1'b0;
   logic               batch_reset_in = 1'b0;
   logic               key_protect_in = 1'b0;
   logic               cpu_fault_in = 1'b0;
   logic               mem_fault_in = 1'b0;
   logic               batch_saved_in = 1'b0;
   logic [15:0]        timer_pv = 16'h0000;
   logic               timing_done = 1'b0;
   logic               pv_clear, timing_run, ctrl_out, batch_out, view_batch, setting_mode;
   logic [3:0]         batch_blank;
   logic [1:0]         err_code, s_axi_bresp, s_axi_rresp, rs;
   logic [7:0]         s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0]        s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0]         s_axi_wstrb = 4'hF;
   logic               s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic               s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic               m_out = 1'b0;
   int                 bad_count = 0, comparisons = 0, m_cnt = 0, m_bsv = 0, v, k;

   btc_ctrl #(.TICK_CYC(4)) u_btc_ctrl (.core_clk, .rst, .keys, .tmr_reset_in,
      .batch_reset_in, .key_protect_in, .cpu_fault_in, .mem_fault_in, .batch_saved_in,
      .timer_pv, .timing_done, .pv_clear, .timing_run, .ctrl_out, .batch_out, .batch_blank,
      .err_code, .view_batch, .setting_mode, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   always #25 core_clk = ~core_clk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   function automatic logic [15:0] bcd(input int x);
      return {4'(x / 1000), 4'(x / 100 % 10), 4'(x / 10 % 10), 4'(x % 10)};
   endfunction

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      bit aw, w;
      int n;
      aw = 0;
      w = 0;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
         if (s_axi_awready && !aw) begin
            aw = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready && !w) begin
            w = 1;
            s_axi_wvalid <= 1'b0;
         end
      end while (!s_axi_bvalid && n < 40);
      rs = s_axi_bresp;
      if (n >= 40) bad_count++;
   endtask

   task automatic rdr(input logic [7:0] a);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 40);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      if (n >= 40) bad_count++;
   endtask

   task automatic press(input logic [7:0] key);
      keys <= btc_pkg::btc_keys_s'(key);
      cyc(5);
      keys <= '0;
      cyc(5);
   endtask

   task automatic pulse();
      timing_done <= 1'b1;
      cyc(1);
      timing_done <= 1'b0;
      cyc(1);
      m_cnt = (m_cnt + 1) % 10000;
      if (m_bsv != 0 && m_cnt >= m_bsv) m_out = 1'b1;
   endtask

   task automatic setb(input int x);
      wr(btc_pkg::OFS_BATCH_SV, bcd(x));
      m_bsv = x;
      if (m_bsv != 0 && m_cnt >= m_bsv) m_out = 1'b1;
   endtask

   // batch count and output against the model
   task automatic cb();
      cyc(3);
      rdr(btc_pkg::OFS_BATCH_PV);
      chk(rd, {16'h0000, bcd(m_cnt)});
      chk(batch_out, m_out);
   endtask

   // pulses during reset are ignored
   task automatic breset();
      batch_reset_in <= 1'b1;
      cyc(4);
      pulse();
      batch_reset_in <= 1'b0;
      cyc(3);
      m_cnt = 0;
      m_out = 1'b0;
   endtask

   task automatic end_of_test();
      if (bad_count == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      #2_000_000;
      bad_count++;
      end_of_test();
   end

   initial begin
      void'($urandom(83));
      cyc(5);
      rst <= 1'b0;
      cyc(1);
      rdr(btc_pkg::OFS_OSH_TIME);
      chk(rd, 32'h0000_1001);
      rdr(8'h14);
      chk(rs, btc_pkg::RESP_SLVERR);
      wr(btc_pkg::OFS_STATUS, 16'h0003);
      chk(rs, btc_pkg::RESP_SLVERR);
      v = $urandom_range(100, 9998);
      wr(btc_pkg::OFS_TIMER_SV, 16'h9999);
      timer_pv <= bcd(v);
      // the latch set by the all-zero start holds until a timer reset
      tmr_reset_in <= 1'b1;
      cyc(5);
      tmr_reset_in <= 1'b0;
      cyc(4);
      chk(ctrl_out, 1'b0);
      wr(btc_pkg::OFS_TIMER_SV, bcd(v - 1));
      cyc(3);
      chk(ctrl_out, 1'b1);
      breset();
      k = $urandom_range(2, 5);
      setb(k);
      repeat (k - 1) pulse();
      cb();
      pulse();
      cb();
      setb(k + 3);
      cb();
      tmr_reset_in <= 1'b1;
      cyc(5);
      chk(ctrl_out, 1'b0);
      tmr_reset_in <= 1'b0;
      cb();
      breset();
      cb();
      setb(6);
      repeat (4) pulse();
      cb();
      setb(3);
      cb();
      breset();
      setb(0);
      repeat (9999) pulse();
      cb();
      pulse();
      cb();
      batch_saved_in <= 1'b1;
      rst <= 1'b1;
      cyc(2);
      rst <= 1'b0;
      cyc(6);
      chk(batch_out, 1'b1);
      setb(105);
      cyc(2);
      chk(batch_blank, 4'h8);
      press(8'h02);
      chk(view_batch, 1'b1);
      press(8'h10);
      rdr(btc_pkg::OFS_BATCH_SV);
      chk(rd, 32'h0000_0106);
      press(8'h04);
      chk(view_batch, 1'b0);
      wr(btc_pkg::OFS_TIMER_SV, 16'h9234);
      press(8'h80);
      press(8'h20);
      rdr(btc_pkg::OFS_TIMER_SV);
      chk(rd, 32'h0000_0244);
      key_protect_in <= 1'b1;
      press(8'h08);
      chk(setting_mode, 1'b0);
      key_protect_in <= 1'b0;
      cyc(3);
      press(8'h08);
      chk(setting_mode, 1'b1);
      chk(timing_run, 1'b1);
      press(8'h10);
      rdr(btc_pkg::OFS_OSH_TIME);
      chk(rd, 32'h0000_1001);
      press(8'h04);
      rdr(btc_pkg::OFS_OSH_TIME);
      chk(rd, 32'h0000_1002);
      for (int i = 0; i < 2; i++) begin
         cpu_fault_in <= (i == 0);
         mem_fault_in <= (i == 1);
         cyc(5);
         chk(err_code, (i == 0) ? btc_pkg::ERR_CPU : btc_pkg::ERR_MEM);
         chk({batch_out, ctrl_out, pv_clear}, 3'b001);
         cpu_fault_in <= 1'b0;
         mem_fault_in <= 1'b0;
         press(8'h01);
         chk(err_code, btc_pkg::ERR_NONE);
      end
      end_of_test();
   end
endmodule // testbench
